// ### inc/ubg_pkg.sv
// package of constants for the serial baud rate generator
package ubg_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam int ADDR_W = 2;
    localparam int DATA_W = 8;
    localparam logic [1:0] ADDR_BAUD_CTRL = 2'h0;
    localparam logic [1:0] ADDR_MODE = 2'h1;
    localparam logic [1:0] ADDR_FRAME = 2'h2;
    localparam logic [1:0] ADDR_STATUS = 2'h3;

    // ------------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------------
    localparam int SRC_HI = 7;
    localparam int SRC_LO = 6;
    localparam int K_HI = 4;
    localparam int K_LO = 0;
    localparam int MODE_POWER = 7;
    localparam int MODE_TXE = 6;
    localparam int MODE_RXE = 5;
    localparam logic [7:0] BAUD_CTRL_RESET = 8'h08;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [3:0] FRAME_LEN_RESET = 4'ha;
    localparam logic [4:0] K_MIN = 5'h08;

    // ------------------------------------------------------------------
    // prescaler: count limit for each source code, one less than the mclk cycles per base clock
    // ------------------------------------------------------------------
    localparam logic [3:0] PRE_LIMIT_0 = 4'h0;
    localparam logic [3:0] PRE_LIMIT_1 = 4'h1;
    localparam logic [3:0] PRE_LIMIT_2 = 4'h3;
    localparam logic [3:0] PRE_LIMIT_3 = 4'h7;

    // receive sequencer
    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_START = 2'b01,
        RX_DATA = 2'b10
    } ubg_rx_state_t;

endpackage : ubg_pkg

// ### rtl/ubg_divcnt.sv
// 5-bit divider counter with half-period phase flag
module ubg_divcnt
    import ubg_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // control
    input wire logic clear,
    input wire logic tick,
    input wire logic [4:0] k_value,
    // timing pulses
    output logic mid_pulse,
    output logic bit_pulse
);

    typedef struct packed {
        logic [4:0] cnt;
        logic phase;
    } ubg_div_state_t;

    ubg_div_state_t st;
    ubg_div_state_t next_st;
    logic at_k;

    // wrap after k base clocks; two wraps make one bit
    assign at_k = (st.cnt == k_value - 5'h01);
    assign mid_pulse = tick & ~clear & at_k & ~st.phase;
    assign bit_pulse = tick & ~clear & at_k & st.phase;

    // next counter value
    always_comb begin
        next_st = st;
        if (clear) begin
            next_st = '0;
        end else if (tick) begin
            if (at_k) begin
                next_st.cnt = 5'h00;
                next_st.phase = ~st.phase;
            end else begin
                next_st.cnt = st.cnt + 5'h01;
            end
        end
    end

    // state register
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

endmodule : ubg_divcnt

// ### rtl/ubg_top.sv
// baud rate generator: prescaler, tx and rx dividers, receive timing
module ubg_top
    import ubg_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // register port
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // serial unit side
    input wire logic tx_load,
    input wire logic serial_rx_pin,
    output logic base_tick,
    output logic tx_bit_tick,
    output logic rx_filtered,
    output logic rx_busy,
    output logic rx_sample,
    output logic rx_bit,
    output logic rx_frame_done,
    output logic rx_frame_ok
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] baud_gen_control;
        logic [7:0] serial_mode_reg;
        logic [3:0] frame_len;
        logic [7:0] rdata;
        logic [3:0] pre_cnt;
        logic base_tick;
        logic samp_a;
        logic samp_b;
        logic filt;
        logic filt_prev;
        ubg_rx_state_t rx_state;
        logic [3:0] bit_cnt;
        logic tx_bit_tick;
        logic rx_sample;
        logic rx_bit;
        logic rx_frame_done;
        logic rx_frame_ok;
        logic last_ok;
        logic rx_busy;
    } ubg_state_t;

    ubg_state_t st;
    ubg_state_t next_st;

    // ------------------------------------------------------------------
    // decoded control
    // ------------------------------------------------------------------
    logic serial_power_on;
    logic tx_enable_bit;
    logic rx_enable_bit;
    logic clk_src_sel_hi;
    logic clk_src_sel_lo;
    logic [4:0] divisor_k_field;
    logic [4:0] k_eff;
    logic k_invalid;
    logic [3:0] pre_limit;
    logic tx_clear;
    logic rx_clear;
    logic tx_mid;
    logic tx_bit;
    logic rx_mid;
    logic rx_edge;
    logic [7:0] status_word;

    assign serial_power_on = st.serial_mode_reg[MODE_POWER];
    assign tx_enable_bit = st.serial_mode_reg[MODE_TXE];
    assign rx_enable_bit = st.serial_mode_reg[MODE_RXE];
    assign clk_src_sel_hi = st.baud_gen_control[SRC_HI];
    assign clk_src_sel_lo = st.baud_gen_control[SRC_LO];
    assign divisor_k_field = st.baud_gen_control[K_HI:K_LO];

    // k below 8 is out of range; run at 8 so timing stays sane
    assign k_invalid = (divisor_k_field < K_MIN);
    assign k_eff = k_invalid ? K_MIN : divisor_k_field;

    // one fixed prescaler ratio per source code
    always_comb begin
        case ({clk_src_sel_hi, clk_src_sel_lo})
            2'b00: pre_limit = PRE_LIMIT_0;
            2'b01: pre_limit = PRE_LIMIT_1;
            2'b10: pre_limit = PRE_LIMIT_2;
            2'b11: pre_limit = PRE_LIMIT_3;
            default: pre_limit = PRE_LIMIT_0;
        endcase
    end

    // ------------------------------------------------------------------
    // divider counters
    // ------------------------------------------------------------------
    // tx counter held while power or tx enable is off
    // a character load restarts the bit grid
    assign tx_clear = ~(serial_power_on & tx_enable_bit) | tx_load;
    // rx counter held while off; also held while idle
    assign rx_clear = ~(serial_power_on & rx_enable_bit) | (st.rx_state == RX_IDLE);

    // counts base clocks once powered and enabled
    ubg_divcnt u_tx_div (
        .mclk(mclk),
        .resetn(resetn),
        .clear(tx_clear),
        .tick(st.base_tick),
        .k_value(k_eff),
        .mid_pulse(tx_mid),
        .bit_pulse(tx_bit)
    );

    // receive latch instants come from this counter
    ubg_divcnt u_rx_div (
        .mclk(mclk),
        .resetn(resetn),
        .clear(rx_clear),
        .tick(st.base_tick),
        .k_value(k_eff),
        .mid_pulse(rx_mid),
        .bit_pulse(rx_edge)
    );

    // status view of the block's own state
    assign status_word = {rx_busy_w(st.rx_state), st.last_ok, k_invalid,
                          serial_power_on, st.bit_cnt};

    function automatic logic rx_busy_w(input ubg_rx_state_t s);
        rx_busy_w = (s != RX_IDLE);
    endfunction : rx_busy_w

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.rx_sample = 1'b0;
        next_st.rx_frame_done = 1'b0;
        next_st.rx_frame_ok = 1'b0;

        // register writes
        if (reg_wr) begin
            case (reg_addr)
                ADDR_BAUD_CTRL: next_st.baud_gen_control = reg_wdata;
                ADDR_MODE: next_st.serial_mode_reg = reg_wdata;
                ADDR_FRAME: next_st.frame_len = reg_wdata[3:0];
                default: next_st.rdata = st.rdata;
            endcase
        end

        // register reads, data valid the cycle after the strobe
        if (reg_rd) begin
            case (reg_addr)
                ADDR_BAUD_CTRL: next_st.rdata = st.baud_gen_control;
                ADDR_MODE: next_st.rdata = st.serial_mode_reg;
                ADDR_FRAME: next_st.rdata = {4'h0, st.frame_len};
                ADDR_STATUS: next_st.rdata = status_word;
                default: next_st.rdata = 8'h00;
            endcase
        end else begin
            next_st.rdata = 8'h00;
        end

        // prescaler feeds the selected base clock while powered
        // powered off: no base clock edges, output held low
        if (serial_power_on) begin
            if (st.pre_cnt >= pre_limit) begin
                next_st.pre_cnt = 4'h0;
                next_st.base_tick = 1'b1;
            end else begin
                next_st.pre_cnt = st.pre_cnt + 4'h1;
                next_st.base_tick = 1'b0;
            end
        end else begin
            next_st.pre_cnt = 4'h0;
            next_st.base_tick = 1'b0;
        end

        // one tx bit every 2k base clocks
        next_st.tx_bit_tick = tx_bit;

        // two matching samples move the filter, two base clocks of lag
        if (st.base_tick) begin
            next_st.samp_a = serial_rx_pin;
            next_st.samp_b = st.samp_a;
            if (st.samp_a == st.samp_b) begin
                next_st.filt = st.samp_b;
            end
            next_st.filt_prev = st.filt;
        end

        // receive sequencer
        case (st.rx_state)
            RX_IDLE: begin
                // falling edge of filtered input starts the divider
                if (st.base_tick && st.filt_prev && !st.filt) begin
                    next_st.rx_state = RX_START;
                    next_st.bit_cnt = 4'h0;
                end
            end
            RX_START: begin
                // resample at count k; low means a real start bit
                if (rx_mid) begin
                    if (!st.filt) begin
                        next_st.rx_state = RX_DATA;
                        next_st.bit_cnt = 4'h1;
                    end else begin
                        next_st.rx_state = RX_IDLE;
                    end
                end
            end
            RX_DATA: begin
                // latch each bit mid-period, 2k apart
                if (rx_mid) begin
                    next_st.rx_sample = 1'b1;
                    next_st.rx_bit = st.filt;
                    next_st.bit_cnt = st.bit_cnt + 4'h1;
                    // stop after the last bit of the frame
                    if (st.bit_cnt >= st.frame_len - 4'h1) begin
                        next_st.rx_state = RX_IDLE;
                        next_st.rx_frame_done = 1'b1;
                        // frame good only if stop bit latched high
                        next_st.rx_frame_ok = st.filt;
                        next_st.last_ok = st.filt;
                    end
                end
            end
            default: next_st.rx_state = RX_IDLE;
        endcase

        // power or receive enable off aborts reception
        if (!(serial_power_on && rx_enable_bit)) begin
            next_st.rx_state = RX_IDLE;
            next_st.bit_cnt = 4'h0;
        end

        // busy kept as its own flop so the port needs no decode after the register
        next_st.rx_busy = (next_st.rx_state != RX_IDLE);
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st <= '0;
            st.baud_gen_control <= BAUD_CTRL_RESET;
            st.serial_mode_reg <= MODE_RESET;
            st.frame_len <= FRAME_LEN_RESET;
            st.samp_a <= 1'b1;
            st.samp_b <= 1'b1;
            st.filt <= 1'b1;
            st.filt_prev <= 1'b1;
            st.rx_state <= RX_IDLE;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // outputs, all from flops
    // ------------------------------------------------------------------
    assign reg_rdata = st.rdata;
    assign base_tick = st.base_tick;
    assign tx_bit_tick = st.tx_bit_tick;
    assign rx_filtered = st.filt;
    assign rx_busy = st.rx_busy;
    assign rx_sample = st.rx_sample;
    assign rx_bit = st.rx_bit;
    assign rx_frame_done = st.rx_frame_done;
    assign rx_frame_ok = st.rx_frame_ok;

endmodule : ubg_top

// ### verification/uart_baud_rate_generator_test.sv
// self-checking bench for the baud rate generator
module uart_baud_rate_generator_test
    import ubg_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
`define CHK(w, e, a) begin checked++; if ((a) !== (e)) begin n_mismatch++; \
    $display("MISMATCH %s exp %0h seen %0h", w, e, a); end end
    // ----------------------------------------------------------------
    // stimulus, model state and instances
    // ----------------------------------------------------------------
    logic mclk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, tx_load = 1'b0;
    logic go = 1'b0, stop_val = 1'b1;
    logic [1:0] reg_addr = 2'h0;
    logic [7:0] reg_wdata = 8'h00, tx_data = 8'h00, period = 8'h10, reg_rdata;
    logic serial_rx_pin, base_tick, tx_bit_tick, rx_filtered, rx_busy, rem_busy;
    logic rx_sample, rx_bit, rx_frame_done, rx_frame_ok, ok_seen;
    logic [4:0] k;
    logic got[$];
    logic [31:0] seed = 32'haa2a8181;
    int n_mismatch = 0, checked = 0, cycles = 0, done_seen = 0, cnt, c;
    int m_reg[4] = '{8, 0, 10, 0}; // register model: ctrl, mode, frame length, status
    ubg_top u_ubg_top (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .tx_load(tx_load), .serial_rx_pin(serial_rx_pin), .base_tick(base_tick),
        .tx_bit_tick(tx_bit_tick), .rx_filtered(rx_filtered), .rx_busy(rx_busy),
        .rx_sample(rx_sample), .rx_bit(rx_bit), .rx_frame_done(rx_frame_done),
        .rx_frame_ok(rx_frame_ok));
    ubg_remote_tx u_ubg_remote_tx (.mclk(mclk), .go(go), .data(tx_data),
        .stop_val(stop_val), .period(period), .line(serial_rx_pin), .busy(rem_busy));
    // 40 MHz clock
    always #12.5 mclk = ~mclk;
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    task automatic close_out();
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : close_out
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
        if (a != ADDR_STATUS) m_reg[a] = d; // status refuses writes
    endtask : wr
    task automatic rd_chk(input logic [1:0] a, input int e);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        `CHK("reg_rdata", e, reg_rdata)
    endtask : rd_chk
    // settle, then count one-cycle pulses over n cycles
    task automatic count(input bit which, input int n);
        cnt = 0;
        repeat (16) @(posedge mclk);
        repeat (n) begin
            @(posedge mclk);
            #1;
            cnt += ((which ? tx_bit_tick : base_tick) === 1'b1);
        end
    endtask : count
    task automatic next_tick();
        c = 0;
        do begin
            @(posedge mclk);
            #1;
            c++;
        end while (tx_bit_tick !== 1'b1 && c < 2000);
    endtask : next_tick
    // one received frame, source 0, partner bit length per cycles
    task automatic frame(input logic [4:0] kv, input logic [7:0] per, input logic sv);
        int d0;
        d0 = done_seen;
        got.delete();
        wr(ADDR_BAUD_CTRL, {3'h0, kv});
        @(posedge mclk);
        tx_data <= 8'(xs());
        period <= per;
        stop_val <= sv;
        go <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
        for (int i = 0; i < 2000 && done_seen == d0; i++) @(posedge mclk);
        #1;
        `CHK("frame done", d0 + 1, done_seen)
        for (int i = 0; i < 8; i++) `CHK("rx_bit", tx_data[i], got[i])
        `CHK("frame ok", sv, ok_seen)
        `CHK("rx filtered", sv, rx_filtered)
        `CHK("rx busy", 0, rx_busy)
        for (int i = 0; i < 2000 && rem_busy === 1'b1; i++) @(posedge mclk);
    endtask : frame
    // collect latched bits and frame ends as they stand
    always @(posedge mclk) begin
        if (rx_sample === 1'b1) got.push_back(rx_bit);
        if (rx_frame_done === 1'b1) begin
            done_seen++;
            ok_seen = rx_frame_ok;
        end
    end
    // hang guard, the whole run needs well under this
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            close_out();
        end
    end
    initial begin
        repeat (5) @(posedge mclk);
        resetn <= 1'b1;
        for (int a = 0; a < 4; a++) rd_chk(a[1:0], m_reg[a]);
        wr(ADDR_FRAME, 8'h07);
        rd_chk(ADDR_FRAME, m_reg[2]);
        wr(ADDR_FRAME, 8'h0a);
        wr(ADDR_STATUS, 8'hff);
        wr(ADDR_BAUD_CTRL, 8'h05);
        wr(ADDR_MODE, 8'h80);
        rd_chk(ADDR_STATUS, 8'h30);
        rd_chk(ADDR_BAUD_CTRL, m_reg[0]);
        wr(ADDR_MODE, 8'h00);
        count(0, 64);
        `CHK("base off", 0, cnt)
        wr(ADDR_MODE, 8'h80);
        for (int s = 0; s < 4; s++) begin
            wr(ADDR_BAUD_CTRL, {s[1:0], 6'h08});
            count(0, 64);
            `CHK("base ticks", 64 >> s, cnt)
        end
        // the first trial uses an invalid k, which runs as eight
        wr(ADDR_MODE, 8'hc0);
        for (int t = 0; t < 4; t++) begin
            k = (t == 0) ? 5'h03 : 5'h08 + 5'(xs() % 24);
            wr(ADDR_BAUD_CTRL, {2'h1, 1'b0, k});
            @(posedge mclk);
            tx_load <= 1'b1;
            @(posedge mclk);
            tx_load <= 1'b0;
            next_tick();
            next_tick();
            `CHK("tx period", 4 * ((k < K_MIN) ? 8 : k), c)
        end
        wr(ADDR_MODE, 8'h80);
        count(1, 300);
        `CHK("tx off", 0, cnt)
        wr(ADDR_MODE, 8'ha0);
        frame(5'h08, 8'h10, 1'b1);
        frame(5'h10, 8'h21, 1'b1);
        frame(5'h1f, 8'h3c, 1'b1);
        // status: power on, last frame good, ten bits counted start to stop
        rd_chk(ADDR_STATUS, 8'h5a);
        frame(5'h08, 8'h10, 1'b0);
        rd_chk(ADDR_STATUS, 8'h1a);
        close_out();
    end
endmodule : uart_baud_rate_generator_test

// ### verification/ubg_remote_tx.sv
// remote asynchronous transmitter that drives the receive line
module ubg_remote_tx (
    // clock
    input wire logic mclk,
    // frame request
    input wire logic go,
    input wire logic [7:0] data,
    input wire logic stop_val,
    input wire logic [7:0] period,
    // line side
    output logic line,
    output logic busy
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [9:0] bits;
    // one frame per request: start bit, data lsb first, stop, then idle high
    initial begin
        line = 1'b1;
        busy = 1'b0;
        forever begin
            @(posedge mclk);
            if (go === 1'b1) begin
                bits = {stop_val, data, 1'b0};
                busy <= 1'b1;
                for (int i = 0; i < 10; i++) begin
                    line <= bits[i];
                    repeat (period) @(posedge mclk);
                end
                line <= 1'b1; // released line returns to mark level
                busy <= 1'b0;
            end
        end
    end
endmodule : ubg_remote_tx

// ### verification/ubg_top_properties.sv
// port checker for the baud rate generator
module ubg_top_properties
    import ubg_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // register port
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // serial unit side
    input wire logic tx_load,
    input wire logic serial_rx_pin,
    input wire logic base_tick,
    input wire logic tx_bit_tick,
    input wire logic rx_filtered,
    input wire logic rx_busy,
    input wire logic rx_sample,
    input wire logic rx_bit,
    input wire logic rx_frame_done,
    input wire logic rx_frame_ok
);
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {logic [7:0] ctrl; logic [7:0] mode;} ubg_shadow_t;
    ubg_shadow_t sh, next_sh;
    wire logic pwr = sh.mode[MODE_POWER];
    wire logic txon = pwr & sh.mode[MODE_TXE];
    wire logic rxon = pwr & sh.mode[MODE_RXE];
    wire logic kbad = sh.ctrl[K_HI:K_LO] < K_MIN;
    wire logic src3 = sh.ctrl[SRC_HI:SRC_LO] == 2'h3;
    // shadow of control and mode, a write acts from the next cycle
    always_comb begin
        next_sh = sh;
        if (reg_wr && reg_addr == ADDR_BAUD_CTRL) next_sh.ctrl = reg_wdata;
        if (reg_wr && reg_addr == ADDR_MODE) next_sh.mode = reg_wdata;
    end
    // shadow register, reset to the register reset values
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) sh <= {BAUD_CTRL_RESET, MODE_RESET};
        else sh <= next_sh;
    end
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);
    pwr_base_a: assert property (!pwr |=> !base_tick)
        else $error("base clock ticked while powered off");
    src_gap_a: assert property (base_tick && src3 && pwr |=> (!base_tick || !src3)[*7])
        else $error("base clock gap too short for source three");
    tx_hold_a: assert property (!txon && !$past(txon) |=> !tx_bit_tick)
        else $error("tx bit tick while transmit disabled");
    tx_clear_a: assert property (tx_load |-> ##2 (!tx_bit_tick)[*8])
        else $error("tx bit tick too soon after load");
    rx_hold_a: assert property (!rxon && !$past(rxon) |=> !rx_busy)
        else $error("receiver busy while receive disabled");
    rx_start_a: assert property ($rose(rx_busy) |-> !rx_filtered)
        else $error("receiver started without low line");
    rx_stop_a: assert property (rx_frame_done |-> !rx_busy ##2 !rx_busy)
        else $error("receiver kept running after frame");
    rx_latch_a: assert property (rx_sample |-> $past(rx_busy))
        else $error("sample outside a frame");
    frame_ok_a: assert property (rx_frame_ok |-> rx_frame_done)
        else $error("frame ok without frame end");
    status_a: assert property (reg_rd && reg_addr == ADDR_STATUS
        |=> reg_rdata[4] == $past(pwr) && reg_rdata[5] == $past(kbad))
        else $error("status power or divisor flag wrong");
endmodule : ubg_top_properties

bind ubg_top ubg_top_properties u_ubg_top_properties (.mclk(mclk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .tx_load(tx_load), .serial_rx_pin(serial_rx_pin),
    .base_tick(base_tick), .tx_bit_tick(tx_bit_tick), .rx_filtered(rx_filtered),
    .rx_busy(rx_busy), .rx_sample(rx_sample), .rx_bit(rx_bit),
    .rx_frame_done(rx_frame_done), .rx_frame_ok(rx_frame_ok));
